// [crf_cpu_register_file.sv]
// cpu programmer-visible register file with stack sequencing
`timescale 1ns/1ps
`default_nettype none
module crf_cpu_register_file #(
   parameter int IRQ_LINES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // execution-side command
   input wire logic [3:0] op,
   input wire logic [2:0] dst,
   input wire logic [7:0] wrData,
   input wire logic [15:0] pcLoad,
   input wire logic ySelect,
   input wire logic [7:0] result,
   input wire logic resultValid,
   input wire logic carryOut,
   input wire logic halfCarryOut,
   input wire logic pcStep,
   // stack byte moves
   input wire logic push,
   input wire logic pop,
   input wire logic [2:0] pushSel,
   input wire logic [7:0] pushExt,
   input wire logic [2:0] popSel,
   input wire logic [7:0] popData,
   // interrupts
   input wire logic [IRQ_LINES-1:0] irqReq,
   input wire logic irqEnter,
   input wire logic irqReturn,
   input wire logic [IRQ_LINES-1:0] irqAck,
   // state
   output logic [7:0] accumulator,
   output logic [7:0] xIndex,
   output logic [7:0] yIndex,
   output logic [15:0] programCounter,
   output logic [7:0] conditionCode,
   output logic [15:0] stackPointer,
   output logic [7:0] stackWrData,
   output logic [15:0] stackAddr,
   output logic stackWrite,
   output logic [IRQ_LINES-1:0] irqPending,
   output logic irqTake
);
   // ==========================================
   // decode
   crf_pkg::crf_op_e opCode;
   logic ySel;
   logic [7:0] ccNext;
   logic [5:0] spLow;
   logic [7:0] pushByte;
   logic [IRQ_LINES-1:0] next_pending;
   assign opCode = crf_pkg::crf_op_e'(op);

   // ==========================================
   // y prefix stays until an index write or a valid result clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ySel <= 1'b0;
      end else if (clkEn) begin
         if (ySelect) begin
            ySel <= 1'b1;
         end else if (dst == crf_pkg::CRF_W_IDX || resultValid) begin
            ySel <= 1'b0;
         end
      end
   end

   // ==========================================
   // data registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator <= 8'h00;
         xIndex <= 8'h00;
         yIndex <= 8'h00;
      end else if (clkEn) begin
         if (dst == crf_pkg::CRF_W_A) begin
            accumulator <= wrData;
         end
         if (dst == crf_pkg::CRF_W_IDX) begin
            if (ySel || ySelect) begin
               yIndex <= wrData;
            end else begin
               xIndex <= wrData;
            end
         end
         if (pop) begin
            unique case (crf_pkg::crf_sel_e'(popSel))
               crf_pkg::CRF_SEL_A: accumulator <= popData;
               crf_pkg::CRF_SEL_X: xIndex <= popData;
               crf_pkg::CRF_SEL_Y: yIndex <= popData;
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // program counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         programCounter <= crf_pkg::PC_RESET;
      end else if (clkEn) begin
         if (pop && popSel == crf_pkg::CRF_SEL_PCL) begin
            programCounter[7:0] <= popData;
         end else if (pop && popSel == crf_pkg::CRF_SEL_PCH) begin
            programCounter[15:8] <= popData;
         end else if (dst == crf_pkg::CRF_W_PC) begin
            programCounter <= pcLoad;
         end else if (pcStep) begin
            programCounter <= programCounter + 16'h0001;
         end
      end
   end

   // ==========================================
   // condition codes
   always_comb begin
      ccNext = conditionCode;
      if (resultValid) begin
         ccNext[crf_pkg::CC_N] = result[7];
         ccNext[crf_pkg::CC_Z] = (result == 8'h00);
      end
      unique case (opCode)
         crf_pkg::CRF_ADD: begin
            ccNext[crf_pkg::CC_H] = halfCarryOut;
            ccNext[crf_pkg::CC_C] = carryOut;
         end
         crf_pkg::CRF_SHIFT, crf_pkg::CRF_BTJ: ccNext[crf_pkg::CC_C] = carryOut;
         crf_pkg::CRF_SCF: ccNext[crf_pkg::CC_C] = 1'b1;
         crf_pkg::CRF_RCF: ccNext[crf_pkg::CC_C] = 1'b0;
         crf_pkg::CRF_SIM: ccNext[crf_pkg::CC_I] = 1'b1;
         crf_pkg::CRF_RIM: ccNext[crf_pkg::CC_I] = 1'b0;
         crf_pkg::CRF_CCWR: ccNext = wrData;
         default: ;
      endcase
      if (pop && popSel == crf_pkg::CRF_SEL_CC) begin
         ccNext = popData;
      end
      if (irqReturn) begin
         ccNext[crf_pkg::CC_I] = 1'b0;
      end
      if (irqEnter) begin
         ccNext[crf_pkg::CC_I] = 1'b1;
      end
      ccNext = ccNext | crf_pkg::CC_ONES;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conditionCode <= crf_pkg::CC_RESET;
      end else if (clkEn) begin
         conditionCode <= ccNext;
      end
   end

   // ==========================================
   // stack pointer: only six low bits live, so wrap is free
   always_comb begin
      spLow = stackPointer[5:0];
      if (opCode == crf_pkg::CRF_RSP) begin
         spLow = 6'h3F;
      end else if (dst == crf_pkg::CRF_W_SPL) begin
         spLow = wrData[5:0];
      end else if (push) begin
         spLow = stackPointer[5:0] - 6'h01;
      end else if (pop) begin
         spLow = stackPointer[5:0] + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stackPointer <= crf_pkg::SP_RESET;
      end else if (clkEn) begin
         stackPointer <= crf_pkg::SP_FIXED | {10'h000, spLow};
      end
   end

   // ==========================================
   // push byte select; interrupt frame goes pcl, pch, x, a, cc
   always_comb begin
      unique case (crf_pkg::crf_sel_e'(pushSel))
         crf_pkg::CRF_SEL_PCL: pushByte = programCounter[7:0];
         crf_pkg::CRF_SEL_PCH: pushByte = programCounter[15:8];
         crf_pkg::CRF_SEL_X: pushByte = xIndex;
         crf_pkg::CRF_SEL_A: pushByte = accumulator;
         crf_pkg::CRF_SEL_CC: pushByte = conditionCode;
         crf_pkg::CRF_SEL_Y: pushByte = yIndex;
         default: pushByte = pushExt;
      endcase
   end

   // write happens at the current pointer, then the pointer drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stackWrData <= 8'h00;
         stackAddr <= crf_pkg::SP_RESET;
         stackWrite <= 1'b0;
      end else if (clkEn) begin
         stackWrite <= push;
         stackWrData <= pushByte;
         stackAddr <= push ? stackPointer : crf_pkg::SP_FIXED | {10'h000, spLow};
      end
   end

   // ==========================================
   // pending interrupts: set wins over acknowledge
   assign next_pending = (irqPending & ~irqAck) | irqReq;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqPending <= '0;
         irqTake <= 1'b0;
      end else if (clkEn) begin
         irqPending <= next_pending;
         irqTake <= (|next_pending) && !ccNext[crf_pkg::CC_I];
      end
   end

   // ==========================================
   // checks: stack moves are built from these sequences
   sequence sPushOnly;
      clkEn && push && !pop && dst != crf_pkg::CRF_W_SPL && opCode != crf_pkg::CRF_RSP;
   endsequence

   sequence sPopOnly;
      clkEn && pop && !push && dst != crf_pkg::CRF_W_SPL && opCode != crf_pkg::CRF_RSP;
   endsequence

   // first byte of an interrupt frame
   sequence sFrameStart;
      clkEn && push && irqEnter && pushSel == crf_pkg::CRF_SEL_PCL;
   endsequence

   // ==========================================
   // condition code upper bits and stack pointer checks
   AST_CC_ONES: assert property (@(posedge clk) disable iff (!rst_n)
      conditionCode[7:5] == 3'b111)
      else $error("cc upper bits not one");
   AST_SP_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
      stackPointer[15:6] == 10'h003)
      else $error("sp upper bits moved");
   AST_PUSH_DEC: assert property (@(posedge clk) disable iff (!rst_n)
      sPushOnly
      |=> stackPointer[5:0] == $past(stackPointer[5:0]) - 6'h01)
      else $error("push no decrement");
   AST_POP_INC: assert property (@(posedge clk) disable iff (!rst_n)
      sPopOnly
      |=> stackPointer[5:0] == $past(stackPointer[5:0]) + 6'h01)
      else $error("pop no increment");
   AST_WRAP_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
      sPushOnly and stackPointer[5:0] == 6'h00
      |=> stackPointer == 16'h00FF)
      else $error("push did not wrap to top");
   AST_WRAP_UP: assert property (@(posedge clk) disable iff (!rst_n)
      sPopOnly and stackPointer[5:0] == 6'h3F
      |=> stackPointer == 16'h00C0)
      else $error("pop did not wrap to bottom");
   AST_RSP: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_RSP
      |=> stackPointer == 16'h00FF)
      else $error("rsp failed");
   AST_SPL_LD: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && dst == crf_pkg::CRF_W_SPL && opCode != crf_pkg::CRF_RSP
      |=> stackPointer[5:0] == $past(wrData[5:0]))
      else $error("sp low load");

   // ==========================================
   // stack write port checks; the write lands where the pointer stood
   AST_STACK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && push
      |=> stackWrite && stackAddr == $past(stackPointer))
      else $error("push address wrong");
   AST_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && !push
      |=> !stackWrite)
      else $error("stray stack write");
   AST_FRAME_PCL: assert property (@(posedge clk) disable iff (!rst_n)
      sFrameStart
      |=> stackWrite && stackWrData == $past(programCounter[7:0]) && conditionCode[crf_pkg::CC_I])
      else $error("frame does not open with pc low");
   AST_PUSH_CC: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && push && pushSel == crf_pkg::CRF_SEL_CC
      |=> stackWrData == $past(conditionCode))
      else $error("cc push data");
   AST_POP_CC: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && pop && popSel == crf_pkg::CRF_SEL_CC && !irqEnter && !irqReturn
      |=> conditionCode == ($past(popData) | crf_pkg::CC_ONES))
      else $error("cc pop data");

   // ==========================================
   // data register checks; a pop to the same register takes priority
   AST_ACC_WR: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && dst == crf_pkg::CRF_W_A && !pop
      |=> accumulator == $past(wrData))
      else $error("accumulator write");
   AST_X_WR: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && dst == crf_pkg::CRF_W_IDX && !ySel && !ySelect && !pop
      |=> xIndex == $past(wrData) && $stable(yIndex))
      else $error("x index write");
   AST_Y_WR: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && dst == crf_pkg::CRF_W_IDX && (ySel || ySelect) && !pop
      |=> yIndex == $past(wrData) && $stable(xIndex))
      else $error("y prefix ignored");
   AST_Y_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && (irqEnter || irqReturn) && dst != crf_pkg::CRF_W_IDX && !(pop && popSel == crf_pkg::CRF_SEL_Y)
      |=> $stable(yIndex))
      else $error("y moved by interrupt");
   AST_PC_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && pcStep && !pop && dst != crf_pkg::CRF_W_PC
      |=> programCounter == $past(programCounter) + 16'h0001)
      else $error("pc step");
   AST_PC_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && dst == crf_pkg::CRF_W_PC && !pop
      |=> programCounter == $past(pcLoad))
      else $error("pc load");

   // ==========================================
   // flag checks
   AST_ENTER_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && irqEnter
      |=> conditionCode[crf_pkg::CC_I])
      else $error("mask not set");
   AST_SIM: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_SIM && !pop && !irqReturn
      |=> conditionCode[crf_pkg::CC_I])
      else $error("mask set instruction");
   AST_RIM: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_RIM && !pop && !irqEnter
      |=> !conditionCode[crf_pkg::CC_I])
      else $error("mask clear instruction");
   AST_INTERRUPT_RETURN_INSTR: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && irqReturn && !irqEnter
      |=> !conditionCode[crf_pkg::CC_I])
      else $error("interrupt_return_instr mask");
   AST_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && resultValid && !pop && opCode != crf_pkg::CRF_CCWR
      |=> conditionCode[crf_pkg::CC_Z] == ($past(result) == 8'h00))
      else $error("z wrong");
   AST_NEG: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && resultValid && !pop && opCode != crf_pkg::CRF_CCWR
      |=> conditionCode[crf_pkg::CC_N] == $past(result[7]))
      else $error("n wrong");
   AST_HALF: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_ADD && !pop
      |=> conditionCode[crf_pkg::CC_H] == $past(halfCarryOut))
      else $error("half carry");
   AST_ADD_CARRY: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_ADD && !pop
      |=> conditionCode[crf_pkg::CC_C] == $past(carryOut))
      else $error("add carry");
   AST_SCF: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_SCF && !pop
      |=> conditionCode[crf_pkg::CC_C])
      else $error("carry set instruction");
   AST_RCF: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && opCode == crf_pkg::CRF_RCF && !pop
      |=> !conditionCode[crf_pkg::CC_C])
      else $error("carry clear instruction");

   // ==========================================
   // interrupt latch checks; take is registered beside the mask, so they agree
   AST_PEND: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && irqReq[0]
      |=> irqPending[0])
      else $error("request lost");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && irqPending[0] && !irqAck[0]
      |=> irqPending[0])
      else $error("pending dropped without ack");
   AST_ACK: assert property (@(posedge clk) disable iff (!rst_n)
      clkEn && irqAck[0] && !irqReq[0]
      |=> !irqPending[0])
      else $error("ack ignored");
   AST_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
      irqTake == ((|irqPending) && !conditionCode[crf_pkg::CC_I]))
      else $error("take disagrees with mask");
   AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
      !clkEn
      |=> $stable(programCounter) && $stable(stackPointer) && $stable(conditionCode) && $stable(irqPending))
      else $error("state moved while frozen");
endmodule // crf_cpu_register_file
`default_nettype wire

// [crf_pkg.sv]
// constants and types for the cpu register file
// Contract
// - an 8-bit accumulator holds operands and takes results
// - two 8-bit index registers, x and y
// - a y-select prefix makes the next instruction use y instead of x
// - y is never saved or restored by interrupt entry and return
// - 16-bit program counter split into low and high bytes
// - condition code bits 7..5 read one, mask is one after reset
// - the whole condition code register can be pushed and popped
// - add and add-with-carry set half carry on carry from bit 3, else clear
// - mask set on interrupt entry or mask set instruction, cleared by software
// - requests arriving while masked stay pending until the mask clears
// - interrupt return clears the mask
// - negative flag takes bit 7 of each result
// - zero flag is set when the result is zero
// - carry follows arithmetic, shifts, bit tests; set and clear instructions force it
// - stack pointer names next free byte; decrement after push, increment before pop
// - upper ten stack pointer bits fixed, 64-byte stack, reset value 00ff
// - reset and stack reset instruction set the six low stack pointer bits
// - load instruction reads and writes the stack pointer low byte
// - stack pointer wraps silently at both limits
// - interrupt entry stores the program counter low byte first, then lower
// - a call uses two stack bytes, an interrupt five
package crf_pkg;
   // ==========================================
   // reset values and field positions
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [15:0] SP_FIXED = 16'h00C0;
   localparam int SP_VAR_BITS = 6;
   localparam logic [7:0] CC_ONES = 8'h00E0;
   localparam logic [7:0] CC_RESET = 8'h00E8;
   localparam int CC_H = 4;
   localparam int CC_I = 3;
   localparam int CC_N = 2;
   localparam int CC_Z = 1;
   localparam int CC_C = 0;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam int CALL_BYTES = 2;
   localparam int IRQ_BYTES = 5;

   // ==========================================
   // instruction-level commands from the execution logic
   typedef enum logic [3:0] {
      CRF_NOP, CRF_ADD, CRF_LOGIC, CRF_SHIFT, CRF_BTJ, CRF_SCF, CRF_RCF,
      CRF_SIM, CRF_RIM, CRF_RSP, CRF_CCWR
   } crf_op_e;

   // stack byte selectors; sequencer order of an interrupt frame
   typedef enum logic [2:0] {
      CRF_SEL_PCL, CRF_SEL_PCH, CRF_SEL_X, CRF_SEL_A, CRF_SEL_CC, CRF_SEL_Y, CRF_SEL_EXT
   } crf_sel_e;

   // register write targets
   typedef enum logic [2:0] {
      CRF_W_NONE, CRF_W_A, CRF_W_IDX, CRF_W_SPL, CRF_W_PC
   } crf_dst_e;
endpackage

// [crf_stack_model.sv]
// stack memory model standing at the far side of the register file
`timescale 1ns/1ps
`default_nettype none
module crf_stack_model (
   input wire logic clk,
   input wire logic stackWrite,
   input wire logic [15:0] stackAddr,
   input wire logic [7:0] stackWrData,
   input wire logic [15:0] stackPointer,
   output logic [7:0] popData
);
   logic [7:0] mem [256];
   // ==========================================
   // storage; upper pointer bits are fixed, so the low byte is the whole address
   always_ff @(posedge clk) begin
      if (stackWrite) begin
         mem[stackAddr[7:0]] <= stackWrData;
      end
   end
   // pop reads one above the free slot, wrapping inside the 64-byte window
   assign popData = mem[{2'h3, 6'(stackPointer[5:0] + 6'h01)}];
endmodule // crf_stack_model
`default_nettype wire

// [crf_cpu_register_file_test.sv]
// self-checking bench for the cpu register file
`timescale 1ns/1ps
`default_nettype none
module crf_cpu_register_file_test;
   logic clk = '0;
   logic rst_n = '0;
   logic clkEn = 1'h1;
   logic [3:0] op = '0;
   logic [2:0] dst = '0, pushSel = '0, popSel = '0;
   logic [7:0] wrData = '0, result = '0, pushExt = '0, popData;
   logic [15:0] pcLoad = '0;
   logic ySelect = '0, resultValid = '0, carryOut = '0, halfCarryOut = '0, pcStep = '0;
   logic push = '0, pop = '0, irqEnter = '0, irqReturn = '0, stackWrite, irqTake;
   logic [3:0] irqReq = '0, irqAck = '0, irqPending;
   logic [7:0] accumulator, xIndex, yIndex, conditionCode, stackWrData;
   logic [15:0] programCounter, stackPointer, stackAddr;
   int errors = 0;
   int n_compared = 0;

   always #20 clk = ~clk;

   crf_cpu_register_file #(.IRQ_LINES(4)) dut_u (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .op(op),
      .dst(dst), .wrData(wrData), .pcLoad(pcLoad), .ySelect(ySelect), .result(result),
      .resultValid(resultValid), .carryOut(carryOut), .halfCarryOut(halfCarryOut), .pcStep(pcStep),
      .push(push), .pop(pop), .pushSel(pushSel), .pushExt(pushExt), .popSel(popSel), .popData(popData),
      .irqReq(irqReq), .irqEnter(irqEnter), .irqReturn(irqReturn), .irqAck(irqAck),
      .accumulator(accumulator), .xIndex(xIndex), .yIndex(yIndex), .programCounter(programCounter),
      .conditionCode(conditionCode), .stackPointer(stackPointer), .stackWrData(stackWrData),
      .stackAddr(stackAddr), .stackWrite(stackWrite), .irqPending(irqPending), .irqTake(irqTake));

   crf_stack_model stk_u (.clk(clk), .stackWrite(stackWrite), .stackAddr(stackAddr),
      .stackWrData(stackWrData), .stackPointer(stackPointer), .popData(popData));

   // ==========================================
   // shared tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one edge with all pulses dropped; outputs settle 1 ns later
   task automatic tick();
      @(posedge clk);
      op <= '0;
      dst <= '0;
      ySelect <= '0;
      resultValid <= '0;
      pcStep <= '0;
      push <= '0;
      pop <= '0;
      irqEnter <= '0;
      irqReturn <= '0;
      irqReq <= '0;
      irqAck <= '0;
      #1;
   endtask

   task automatic opc(input crf_pkg::crf_op_e o);
      @(posedge clk);
      op <= o;
      tick();
   endtask

   task automatic wr(input crf_pkg::crf_dst_e d, input logic [7:0] w, input logic y);
      @(posedge clk);
      dst <= d;
      wrData <= w;
      ySelect <= y;
      tick();
   endtask

   task automatic alu(input logic [7:0] r, input logic c, input logic h);
      @(posedge clk);
      op <= crf_pkg::CRF_ADD;
      resultValid <= 1'h1;
      result <= r;
      carryOut <= c;
      halfCarryOut <= h;
      tick();
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      chk("cc", conditionCode, 8'hE8);
      chk("sp", stackPointer, 16'h00FF);
      wr(crf_pkg::CRF_W_A, 8'h5A, '0);
      wr(crf_pkg::CRF_W_IDX, 8'h3C, '0);
      wr(crf_pkg::CRF_W_IDX, 8'h77, 1'h1);
      chk("a", accumulator, 8'h5A);
      chk("x", xIndex, 8'h3C);
      chk("y", yIndex, 8'h77);
      @(posedge clk);
      dst <= crf_pkg::CRF_W_PC;
      pcLoad <= 16'h12FF;
      @(posedge clk);
      dst <= crf_pkg::CRF_W_NONE;
      pcStep <= 1'h1;
      tick();
      chk("pc", programCounter, 16'h1300);
      $display("registers done");
   endtask

   task automatic t_flags();
      alu(8'h80, 1'h1, 1'h1);
      chk("cc", conditionCode, 8'hFD);
      alu(8'h00, '0, '0);
      chk("cc", conditionCode, 8'hEA);
      opc(crf_pkg::CRF_SCF);
      chk("cc", conditionCode, 8'hEB);
      opc(crf_pkg::CRF_RCF);
      opc(crf_pkg::CRF_RIM);
      chk("cc", conditionCode, 8'hE2);
      opc(crf_pkg::CRF_SIM);
      chk("cc", conditionCode, 8'hEA);
      $display("flags done");
   endtask

   task automatic t_irq();
      @(posedge clk);
      irqReq <= 4'h2;
      tick();
      tick();
      tick();
      chk("pending", irqPending, 4'h2);
      chk("take", irqTake, '0);
      opc(crf_pkg::CRF_RIM);
      tick();
      chk("take", irqTake, 1'h1);
      @(posedge clk);
      irqAck <= 4'h2;
      tick();
      chk("pending", irqPending, 4'h0);
      $display("interrupt latch done");
   endtask

   task automatic t_frame();
      crf_pkg::crf_sel_e s [5] = '{crf_pkg::CRF_SEL_PCL, crf_pkg::CRF_SEL_PCH,
         crf_pkg::CRF_SEL_X, crf_pkg::CRF_SEL_A, crf_pkg::CRF_SEL_CC};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         push <= 1'h1;
         pushSel <= s[i];
         irqEnter <= (i == 0);
      end
      tick();
      tick();
      chk("sp", stackPointer, 16'h00FA);
      chk("cc", conditionCode, 8'hEA);
      chk("pcl", stk_u.mem[8'hFF], 8'h00);
      chk("pch", stk_u.mem[8'hFE], 8'h13);
      chk("x", stk_u.mem[8'hFD], 8'h3C);
      chk("a", stk_u.mem[8'hFC], 8'h5A);
      wr(crf_pkg::CRF_W_A, 8'h11, '0);
      wr(crf_pkg::CRF_W_IDX, 8'h22, '0);
      for (int i = 4; i >= 0; i--) begin
         @(posedge clk);
         pop <= 1'h1;
         popSel <= s[i];
         irqReturn <= (i == 0);
      end
      tick();
      chk("sp", stackPointer, 16'h00FF);
      chk("cc", conditionCode, 8'hE2);
      chk("a", accumulator, 8'h5A);
      chk("x", xIndex, 8'h3C);
      chk("y", yIndex, 8'h77);
      chk("pc", programCounter, 16'h1300);
      $display("interrupt frame done");
   endtask

   task automatic t_stack();
      wr(crf_pkg::CRF_W_SPL, 8'hC0, '0);
      chk("sp", stackPointer, 16'h00C0);
      @(posedge clk);
      push <= 1'h1;
      pushSel <= crf_pkg::CRF_SEL_EXT;
      pushExt <= 8'hAB;
      tick();
      tick();
      chk("sp", stackPointer, 16'h00FF);
      chk("byte", stk_u.mem[8'hC0], 8'hAB);
      @(posedge clk);
      pop <= 1'h1;
      popSel <= crf_pkg::CRF_SEL_EXT;
      tick();
      chk("sp", stackPointer, 16'h00C0);
      wr(crf_pkg::CRF_W_SPL, 8'h12, '0);
      chk("sp", stackPointer, 16'h00D2);
      opc(crf_pkg::CRF_RSP);
      chk("sp", stackPointer, 16'h00FF);
      $display("stack pointer done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      t_reset();
      t_flags();
      t_irq();
      t_frame();
      t_stack();
      finish_test();
   end

   // the whole run needs well under 200 cycles
   initial begin
      #200000;
      errors++;
      finish_test();
   end
endmodule // crf_cpu_register_file_test
`default_nettype wire
